// ### src/pcs_pkg.sv
// package: register map, field layout and reset values of the program counter block
package pcs_pkg;
    // register byte addresses on the apb bus (printed offsets are not all multiples of four: index times four)
    localparam logic [7:0] PCS_IDX_PC_LOW = 8'h02;
    localparam logic [7:0] PCS_IDX_PC_UPPER_BUF = 8'h0a;
    localparam logic [7:0] PCS_IDX_PC_STATUS = 8'h40;
    localparam logic [11:0] PCS_ADDR_PC_LOW = 12'h008;
    localparam logic [11:0] PCS_ADDR_PC_UPPER_BUF = 12'h028;
    localparam logic [11:0] PCS_ADDR_PC_STATUS = 12'h100;
    // widths
    localparam int PCS_PC_W = 13;
    localparam int PCS_BUF_W = 5;
    localparam int PCS_DEPTH = 8;
    localparam int PCS_PTR_W = 3;
    localparam int PCS_JUMP_W = 11;
    // fields
    localparam int PCS_PAGE_BIT = 3;
    // reset values
    localparam logic [7:0] PCS_RST_PC_LOW = 8'h00;
    localparam logic [4:0] PCS_RST_UPPER_BUF = 5'h00;
    localparam logic [12:0] PCS_RST_PC = 13'h0000;
    // sequencer operations
    typedef enum logic [2:0] {
        PCS_OP_STEP = 3'b000,
        PCS_OP_JUMP = 3'b001,
        PCS_OP_CALL = 3'b010,
        PCS_OP_RET = 3'b011,
        PCS_OP_IRQ = 3'b100,
        PCS_OP_HOLD = 3'b101
    } pcs_op_t;
    // apb slave phases
    typedef enum logic [0:0] {
        PCS_BUS_IDLE = 1'b0,
        PCS_BUS_DONE = 1'b1
    } pcs_bus_t;
endpackage : pcs_pkg

// ### src/pcs_ret_stack.sv
// circular eight-entry return address stack
`timescale 1ns/10ps
module pcs_ret_stack (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [12:0] push_addr_i,
    output logic [12:0] top_o
);
    typedef struct packed {
        logic [pcs_pkg::PCS_PTR_W-1:0] ptr;
        logic [pcs_pkg::PCS_DEPTH-1:0][pcs_pkg::PCS_PC_W-1:0] mem;
    } pcs_stk_t;
    pcs_stk_t s_q;
    pcs_stk_t s_d;
    logic [pcs_pkg::PCS_PTR_W-1:0] top_idx;

    // top entry lies one below the write pointer
    assign top_idx = s_q.ptr - 3'h1;
    assign top_o = s_q.mem[top_idx];

    // next state: pointer wraps silently both ways
    always_comb begin
        s_d = s_q;
        if (push_i) begin
            s_d.mem[s_q.ptr] = push_addr_i; // see [R5]
            s_d.ptr = s_q.ptr + 3'h1; // see [R10]
        end else if (pop_i) begin
            s_d.ptr = top_idx;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : pcs_ret_stack

// ### src/pcs_apb_slave.sv
// apb slave front end: decodes a transfer and answers one cycle later
`timescale 1ns/10ps
module pcs_apb_slave (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] rdata_i,
    output logic acc_o,
    output logic pready_o,
    output logic [31:0] prdata_o
);
    typedef struct packed {
        pcs_pkg::pcs_bus_t st;
        logic ready;
        logic [31:0] rdata;
    } pcs_bus_st_t;
    pcs_bus_st_t b_q;
    pcs_bus_st_t b_d;

    // access phase completes when ready is seen high
    assign acc_o = psel_i & penable_i & b_q.ready;
    assign pready_o = b_q.ready;
    assign prdata_o = b_q.rdata;

    // one wait state in the access phase, then ready with read data
    always_comb begin
        b_d = b_q;
        b_d.ready = 1'b0;
        case (b_q.st)
            pcs_pkg::PCS_BUS_IDLE: begin
                if (psel_i && penable_i && !b_q.ready) begin
                    b_d.ready = 1'b1;
                    b_d.rdata = pwrite_i ? 32'h0000_0000 : rdata_i;
                    b_d.st = pcs_pkg::PCS_BUS_DONE;
                end
            end
            pcs_pkg::PCS_BUS_DONE: begin
                b_d.st = pcs_pkg::PCS_BUS_IDLE;
            end
            default: begin
                b_d.st = pcs_pkg::PCS_BUS_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            b_q <= '0;
        end else begin
            b_q <= b_d;
        end
    end
endmodule : pcs_apb_slave

// ### src/pcs_prog_counter.sv
// program counter with upper-bits buffer, return stack and page selection
// Function
// [R1] counter is 13 bits; low byte readable and writable by software
// [R2] upper bits 12:8 not directly accessible; loaded only from the buffer
// [R3] 5-bit buffer feeds the upper counter bits
// [R4] low byte and buffer decode the same address whatever bank; code compares all 12 address bits, other banks select nothing
// [R5] return stack holds eight 13-bit addresses
// [R6] stack and its pointer are invisible to software
// [R7] push on call instruction or interrupt branch
// [R8] pop on return, return with literal, interrupt exit; the code pops only on PCS_OP_RET
// [R9] push and pop leave the buffer unchanged
// [R10] ninth push overwrites the first, silently
// [R11] jump and call carry 11 address bits, one 2K page
// [R12] address bit 11 for jump and call comes from buffer bit 3
// [R13] software sets the page bit before jump or call
// [R14] push saves all 13 bits, returns need no page change
// [R15] writing the low byte loads upper bits from the buffer
// [R16] reset clears low byte and buffer, start at zero
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module pcs_prog_counter (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    input wire logic [2:0] op_i,
    input wire logic [10:0] target_i,
    input wire logic [12:0] irq_vector_i,
    output logic [12:0] pc_o
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [12:0] pc;
        logic [4:0] upper_buf;
        logic err;
    } pcs_state_t;
    pcs_state_t s_q;
    pcs_state_t s_d;

    logic acc;
    logic [31:0] rdata;
    logic [12:0] stack_top;
    logic push;
    logic pop;
    pcs_pkg::pcs_op_t op;

    // full 12-bit address compared: any other bank bits above the word index select no register
    function automatic logic [1:0] pcs_decode(input logic [11:0] addr);
        pcs_decode = 2'b00;
        if (addr == pcs_pkg::PCS_ADDR_PC_LOW) pcs_decode = 2'b01; // see [R4]
        else if (addr == pcs_pkg::PCS_ADDR_PC_UPPER_BUF) pcs_decode = 2'b10; // see [R4]
        else if (addr == pcs_pkg::PCS_ADDR_PC_STATUS) pcs_decode = 2'b11;
    endfunction : pcs_decode

    assign op = pcs_pkg::pcs_op_t'(op_i);
    assign push = (op == pcs_pkg::PCS_OP_CALL) || (op == pcs_pkg::PCS_OP_IRQ); // see [R7]
    assign pop = (op == pcs_pkg::PCS_OP_RET); // see [R8]

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    // stack pointer is never readable
    always_comb begin
        rdata = 32'h0000_0000;
        case (pcs_decode(paddr_i))
            2'b01: rdata = {24'h00_0000, s_q.pc[7:0]}; // see [R1]
            2'b10: rdata = {27'h000_0000, s_q.upper_buf}; // see [R3]
            2'b11: rdata = {24'h00_0000, s_q.pc[7:0]}; // see [R2] upper counter bits stay hidden
            default: rdata = 32'h0000_0000; // see [R6]
        endcase
    end

    pcs_apb_slave u_bus (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .rdata_i(rdata),
        .acc_o(acc),
        .pready_o(pready_o),
        .prdata_o(prdata_o)
    );

    pcs_ret_stack u_stack (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .push_i(push),
        .pop_i(pop),
        .push_addr_i(s_q.pc + 13'h0001), // see [R14]
        .top_o(stack_top)
    );

    // ----------------------------------------
    // next counter value
    // ----------------------------------------
    // software write to low byte wins over sequencer in the same cycle
    always_comb begin
        s_d = s_q;
        s_d.err = acc & (pcs_decode(paddr_i) == 2'b00);
        case (op)
            pcs_pkg::PCS_OP_STEP: s_d.pc = s_q.pc + 13'h0001;
            pcs_pkg::PCS_OP_JUMP,
            pcs_pkg::PCS_OP_CALL: begin
                s_d.pc = {s_q.upper_buf[4], s_q.upper_buf[pcs_pkg::PCS_PAGE_BIT], target_i}; // see [R11] [R12]
            end
            pcs_pkg::PCS_OP_RET: s_d.pc = stack_top; // see [R8] [R9]
            pcs_pkg::PCS_OP_IRQ: s_d.pc = irq_vector_i; // see [R7]
            default: s_d.pc = s_q.pc;
        endcase
        if (acc && pwrite_i && pstrb_i[0]) begin
            if (pcs_decode(paddr_i) == 2'b01) begin
                s_d.pc = {s_q.upper_buf, pwdata_i[7:0]}; // see [R15] [R2]
            end else if (pcs_decode(paddr_i) == 2'b10) begin
                s_d.upper_buf = pwdata_i[4:0]; // see [R3]
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_q.pc <= pcs_pkg::PCS_RST_PC; // see [R16]
            s_q.upper_buf <= pcs_pkg::PCS_RST_UPPER_BUF; // see [R16]
            s_q.err <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pc_o = s_q.pc;
    assign pslverr_o = s_q.err;
endmodule : pcs_prog_counter

// ### testbench/pcs_pc_monitor.sv
// checker: port level properties of the program counter
`timescale 1ns/10ps
module pcs_pc_monitor (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic pready_o,
    input wire logic [31:0] prdata_o,
    input wire logic pslverr_o,
    input wire logic [2:0] op_i,
    input wire logic [10:0] target_i,
    input wire logic [12:0] irq_vector_i,
    input wire logic [12:0] pc_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_ready_one_wait: assert property (psel_i && penable_i && !pready_o && !$past(penable_i) |=> pready_o)
        else $error("ready late");
    a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready long");
    a_step_count: assert property (op_i == 3'h0 && !psel_i |=> pc_o == $past(pc_o) + 13'h1)
        else $error("step wrong");
    a_hold_still: assert property (op_i == 3'h5 && !psel_i |=> $stable(pc_o)) else $error("hold moved");
    a_jump_low: assert property ((op_i == 3'h1 || op_i == 3'h2) && !psel_i |=> pc_o[10:0] == $past(target_i))
        else $error("jump target");
    a_jump_page: assert property (op_i == 3'h1 && !psel_i ##1 op_i == 3'h1 && !psel_i |=> $stable(pc_o[12:11]))
        else $error("page moved");
    a_irq_vector: assert property (op_i == 3'h4 && !psel_i |=> pc_o == $past(irq_vector_i))
        else $error("vector");
    a_call_return: assert property (op_i == 3'h2 && !psel_i ##1 op_i == 3'h3 && !psel_i |=> pc_o == $past(pc_o, 2) + 13'h1)
        else $error("return addr");
    a_reset_zero: assert property ($fell(sys_rst_i) |-> pc_o == 13'h0 && !pready_o) else $error("reset");
    a_unmapped_zero: assert property (pready_o && !pwrite_i && paddr_i == 12'h004 |-> prdata_o == 32'h0)
        else $error("unmapped");
endmodule : pcs_pc_monitor
bind pcs_prog_counter pcs_pc_monitor chk_u (.*);

// ### testbench/pcs_seq_model.sv
// partner: sequencer issuing one operation per cycle
`timescale 1ns/10ps
module pcs_seq_model (
    input wire logic clk_i,
    output logic [2:0] op_o,
    output logic [10:0] target_o,
    output logic [12:0] vector_o
);
    initial begin
        op_o = 3'h5;
        target_o = 11'h0;
        vector_o = 13'h0;
    end
    // next operation, launched just after an edge
    task drive(input logic [2:0] o, input logic [10:0] t, input logic [12:0] v);
        @(posedge clk_i);
        op_o <= o;
        target_o <= t;
        vector_o <= v;
    endtask : drive
endmodule : pcs_seq_model

// ### testbench/tb.sv
// testbench: random sequencer traffic and apb accesses against a counter model
`timescale 1ns/10ps
module tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pready_o, pslverr_o;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0, prdata_o, r, rv;
    logic [3:0] pstrb_i = 4'hf;
    logic [2:0] op_i, o, sp = 3'h0;
    logic [10:0] target_i;
    logic [12:0] irq_vector_i, pc_o, m_pc = 13'h0;
    logic [12:0] stk [8];
    logic [4:0] m_buf = 5'h0;
    logic [11:0] adr [4] = '{12'h008, 12'h028, 12'h100, 12'h004};
    int dep = 0, n_mismatch = 0, total_checks = 0, i, j;
    integer seed = 32'h2ecf;
    always #5 clk_i = ~clk_i;
    pcs_prog_counter dut_u (.*);
    pcs_seq_model seq_u (.clk_i(clk_i), .op_o(op_i), .target_o(target_i), .vector_o(irq_vector_i));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // reference counter with circular stack
    task model(input logic [2:0] o, input logic [10:0] t, input logic [12:0] v);
        if (o == 3'h2 || o == 3'h4) begin
            stk[sp] = m_pc + 13'h1;
            sp++;
            dep = (dep < 8) ? dep + 1 : 8;
        end
        if (o == 3'h3) begin
            sp--;
            m_pc = stk[sp];
            dep--;
        end else if (o == 3'h0) m_pc++;
        else if (o == 3'h1 || o == 3'h2) m_pc = {m_buf[4:3], t};
        else if (o == 3'h4) m_pc = v;
    endtask : model
    task cyc(input logic [2:0] o, input logic [10:0] t, input logic [12:0] v);
        seq_u.drive(o, t, v);
        @(negedge clk_i);
        check({19'h0, pc_o}, {19'h0, m_pc});
        model(o, t, v);
    endtask : cyc
    // one transfer: request held until pready is sampled high at a rising edge, then released
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        cyc(3'h5, 11'h0, 13'h0);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        r = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (w && pstrb_i[0] && a == 12'h008) m_pc = {m_buf, d[7:0]};
        if (w && pstrb_i[0] && a == 12'h028) m_buf = d[4:0];
        @(negedge clk_i);
        check({31'h0, pslverr_o}, {31'h0, a != 12'h008 && a != 12'h028 && a != 12'h100});
    endtask : apb
    // expected read value of address slot s
    function automatic logic [31:0] exp_rd(input int s);
        exp_rd = 32'h0;
        if (s == 0 || s == 2) exp_rd = {24'h0, m_pc[7:0]};
        if (s == 1) exp_rd = {27'h0, m_buf};
    endfunction : exp_rd
    task rdall;
        for (j = 0; j < 4; j++) begin
            apb(1'b0, adr[j], 32'h0);
            check(r, exp_rd(j));
        end
    endtask : rdall
    task results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rdall();
        apb(1'b1, 12'h028, 32'hffff_ffff);
        apb(1'b1, 12'h008, 32'h0000_0034);
        pstrb_i <= 4'he;
        apb(1'b1, 12'h028, 32'h0000_0000);
        pstrb_i <= 4'hf;
        rdall();
        $display("register test done");
        for (i = 0; i < 18; i++) begin
            rv = $random(seed);
            cyc(i < 10 ? 3'h2 : 3'h3, rv[10:0], 13'h0);
        end
        rdall();
        $display("wrap test done");
        for (i = 0; i < 400; i++) begin
            rv = $random(seed);
            o = 3'($unsigned(rv[15:0]) % 6);
            if (o == 3'h3 && dep == 0) o = 3'h0;
            if (i % 50 == 0) apb(1'b1, 12'h028, rv);
            cyc(o, rv[26:16], rv[12:0]);
        end
        rdall();
        $display("random test done");
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        m_pc = 13'h0;
        m_buf = 5'h0;
        sp = 3'h0;
        dep = 0;
        rdall();
        $display("reset test done");
        results();
    end
endmodule : tb
